// File: hdl/capcmp_params.svh
`ifndef CAPCMP_PARAMS_SVH
`define CAPCMP_PARAMS_SVH

// =====================================================================
// Bus widths
`define ADDR_W 8
`define DATA_W 8
`define CTL_W 6
`define MODE_W 4
`define DUTY_LO_W 2
`define PRESC_W 4
`define T1_W 16
`define T2_W 8

// =====================================================================
// Register byte addresses, unit 1 and unit 2
`define UNIT1_LOW_ADDR 8'h15
`define UNIT1_HIGH_ADDR 8'h16
`define UNIT1_CTL_ADDR 8'h17
`define UNIT2_LOW_ADDR 8'h1B
`define UNIT2_HIGH_ADDR 8'h1C
`define UNIT2_CTL_ADDR 8'h1D

// =====================================================================
// Control register field positions
`define CTL_MODE_LSB 0
`define CTL_MODE_MSB 3
`define CTL_DUTY_LSB 4
`define CTL_DUTY_MSB 5
`define MODE_CMP_BIT 3
`define MODE_CAPT_BIT 2
`define MODE_PWM_TOP 2'h3

// =====================================================================
// Mode select codes
`define MODE_OFF 4'h0
`define MODE_CAPT_FALL 4'h4
`define MODE_CAPT_RISE 4'h5
`define MODE_CAPT_RISE4 4'h6
`define MODE_CAPT_RISE16 4'h7
`define MODE_CMP_SET 4'h8
`define MODE_CMP_CLEAR 4'h9
`define MODE_CMP_SOFT 4'hA
`define MODE_CMP_TRIG 4'hB

// =====================================================================
// Prescaler terminal counts and reset values
`define PRESC_TERM4 4'h3
`define PRESC_TERM16 4'hF
`define PRESC_ZERO 4'h0
`define PRESC_ONE 4'h1
`define CTL_RESET 6'h00
`define BYTE_ZERO 8'h00
`define DUTY_ZERO 2'h0
`define CTL_PAD 2'h0

`endif

// File: hdl/capcmp_pkg.sv
`include "capcmp_params.svh"

package capcmp_pkg;

  // =====================================================================
  // Operating class derived from the mode select field
  typedef enum logic [1:0]
  {
    CLASS_OFF = 2'b00,
    CLASS_CAPTURE = 2'b01,
    CLASS_COMPARE = 2'b10,
    CLASS_PWM = 2'b11
  } mode_class_t;

  // =====================================================================
  // State of the pin synchroniser
  typedef struct packed
  {
    logic stage1;
    logic stage2;
  } sync_state_t;

  // =====================================================================
  // State of one capture/compare/PWM unit
  typedef struct packed
  {
    logic [`CTL_W-1:0] control;
    logic [`DATA_W-1:0] value_low;
    logic [`DATA_W-1:0] value_high;
    logic [`DUTY_LO_W-1:0] duty_latch;
    logic [`PRESC_W-1:0] prescale_count;
    logic pin_prev;
    logic match_prev;
    logic compare_latch;
    logic pwm_latch;
    logic event_flag;
    logic event_irq;
    logic trigger;
    logic pin_owned;
    logic pin_out;
    logic [`DATA_W-1:0] rdata;
  } unit_state_t;

endpackage : capcmp_pkg

// File: hdl/pin_sync.sv
`timescale 1ns/1ps

module pin_sync
  import capcmp_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Asynchronous level in, synchronised level out
  input wire logic async_in,
  output logic sync_out
);

  sync_state_t s_reg;
  sync_state_t s_next;

  // =====================================================================
  // Two stages; only the second stage reads the first
  always_comb
  begin
    s_next = s_reg;
    s_next.stage1 = async_in;
    s_next.stage2 = s_reg.stage1;
  end

  // Constant reset keeps the chain free of port values under reset
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign sync_out = s_reg.stage2;

endmodule : pin_sync

// File: hdl/capcmp_unit.sv
// Functional notes
// - Mode zero turns the unit off and resets its internal state.
// - Capture modes: 0100 falling, 0101 rising, 0110 fourth rising, 0111 sixteenth rising.
// - Each capture event copies the whole 16-bit timer1 count into value bytes.
// - Every capture sets the event flag; only software clears it.
// - A newer capture overwrites an unread earlier one.
// - Prescaler counter sits at zero whenever the unit is not capturing.
// - Switching between capture prescales keeps the counter; spurious events possible.
// - Edge detection watches the pad level even when the pin is an output.
// - Compare: match drives pin high for 1000, low for 1001, sets flag.
// - Mode 1010: match sets the flag only, pin untouched.
// - Mode 1011: match sets flag and pulses trigger clearing timer1.
// - Trigger-caused timer1 clear must not set the timer1 overflow flag.
// - Special event trigger is an output for other on-chip logic.
// - Writing control zero forces the compare output latch low.
// - Writing control zero forces the PWM output latch low.
// - Modes 11xx are PWM; control bits 5:4 are the duty low bits.
// - Control bits 7 and 6 read as zero.
// - Both units in PWM share one timer2 time base and period.
// - Value low, value high and control are each readable; all are writable except value high in PWM.
// - At timer2 period end: latch duty into high byte, set pin unless zero.
// - Pin clears when high byte and latch equal timer2 with phase bits.
// - In PWM the high byte is read-only; duty writes apply next period.
`timescale 1ns/1ps
`include "capcmp_params.svh"

module capcmp_unit
  import capcmp_pkg::*;
#(
  parameter logic [`ADDR_W-1:0] LOW_ADDR = `UNIT1_LOW_ADDR,
  parameter logic [`ADDR_W-1:0] HIGH_ADDR = `UNIT1_HIGH_ADDR,
  parameter logic [`ADDR_W-1:0] CTL_ADDR = `UNIT1_CTL_ADDR
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [`ADDR_W-1:0] reg_addr,
  input wire logic [`DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`DATA_W-1:0] reg_rdata,
  // Timer1 time base
  input wire logic [`T1_W-1:0] timer1_count,
  output logic special_event_trigger,
  // Timer2 time base, shared by both units
  input wire logic [`T2_W-1:0] timer2_count,
  input wire logic [`T2_W-1:0] timer2_period,
  input wire logic timer2_tick,
  input wire logic [`DUTY_LO_W-1:0] timer2_phase,
  // Event flag and its enable
  input wire logic event_flag_clear,
  input wire logic event_enable,
  output logic event_flag,
  output logic event_irq,
  // Unit pin
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_owned
);

  // =====================================================================
  // Mode decode, used for the present and the next control value
  function automatic mode_class_t mode_class(input logic [`MODE_W-1:0] mode);
    mode_class_t c;
    c = CLASS_OFF;
    if (mode[`MODE_CMP_BIT:`MODE_CAPT_BIT] == `MODE_PWM_TOP)
    begin
      c = CLASS_PWM;
    end
    else if (mode[`MODE_CMP_BIT])
    begin
      c = CLASS_COMPARE;
    end
    else if (mode[`MODE_CAPT_BIT])
    begin
      c = CLASS_CAPTURE;
    end
    return c;
  endfunction : mode_class

  // =====================================================================
  // State registers and working signals
  unit_state_t s_reg;
  unit_state_t s_next;
  logic pin_level;
  logic [`MODE_W-1:0] cur_mode;
  mode_class_t cur_class;
  mode_class_t new_class;
  logic rise;
  logic fall;
  logic capture_hit;
  logic match;
  logic match_edge;
  logic period_end;
  logic [`DATA_W+`DUTY_LO_W-1:0] duty_new;
  logic [`DATA_W+`DUTY_LO_W-1:0] duty_live;
  logic [`DATA_W+`DUTY_LO_W-1:0] t2_ext;

  // =====================================================================
  // Pad level into the clock domain; a port write that toggles an
  // output pin is seen here too, so it can cause a capture
  pin_sync u_pin_sync
  (
    .clk(clk),
    .rst_b(rst_b),
    .async_in(pin_in),
    .sync_out(pin_level)
  );

  // =====================================================================
  // Decode of the present state
  assign cur_mode = s_reg.control[`CTL_MODE_MSB:`CTL_MODE_LSB];
  assign cur_class = mode_class(cur_mode);

  // Edges are taken between the synchronised level and its last value
  assign rise = pin_level & ~s_reg.pin_prev;
  assign fall = ~pin_level & s_reg.pin_prev;

  // Compare runs every cycle; only the first cycle of a match counts,
  // since a prescaled timer1 may hold one value for many cycles
  assign match = (timer1_count == {s_reg.value_high, s_reg.value_low});
  assign match_edge = match & ~s_reg.match_prev;

  // Timer2 comes from outside and is the same for both units
  assign period_end = timer2_tick & (timer2_count == timer2_period);
  assign duty_new = {s_reg.value_low, s_reg.control[`CTL_DUTY_MSB:`CTL_DUTY_LSB]};
  assign duty_live = {s_reg.value_high, s_reg.duty_latch};
  assign t2_ext = {timer2_count, timer2_phase};

  // =====================================================================
  // Capture event selection and prescaler
  always_comb
  begin
    capture_hit = 1'b0;
    if (cur_class == CLASS_CAPTURE)
    begin
      unique case (cur_mode)
        `MODE_CAPT_FALL: capture_hit = fall;
        `MODE_CAPT_RISE: capture_hit = rise;
        `MODE_CAPT_RISE4: capture_hit = rise & (s_reg.prescale_count >= `PRESC_TERM4);
        `MODE_CAPT_RISE16: capture_hit = rise & (s_reg.prescale_count >= `PRESC_TERM16);
        default: capture_hit = 1'b0;
      endcase
    end
  end

  // =====================================================================
  // Next state: prescaler, then software writes, then hardware events, then mode effects
  always_comb
  begin
    s_next = s_reg;
    s_next.trigger = 1'b0;
    s_next.pin_prev = pin_level;
    new_class = cur_class;

    // Capture: prescale counts rising edges and restarts on each event
    if (cur_class == CLASS_CAPTURE)
    begin
      if (capture_hit)
      begin
        s_next.prescale_count = `PRESC_ZERO;
      end
      else if (rise)
      begin
        s_next.prescale_count = s_reg.prescale_count + `PRESC_ONE;
      end
    end

    // Software writes; a control write never clears the counter by itself
    if (reg_wr)
    begin
      if (reg_addr == CTL_ADDR)
      begin
        s_next.control = reg_wdata[`CTL_W-1:0];
      end
      else if (reg_addr == LOW_ADDR)
      begin
        s_next.value_low = reg_wdata;
      end
      else if ((reg_addr == HIGH_ADDR) && (cur_class != CLASS_PWM))
      begin
        s_next.value_high = reg_wdata;
      end
    end

    // Captured count overrides a same-cycle software write to the value;
    // nothing guards an unread value, it is simply replaced
    if (capture_hit)
    begin
      s_next.value_high = timer1_count[`T1_W-1:`DATA_W];
      s_next.value_low = timer1_count[`DATA_W-1:0];
    end

    // Compare actions on the first cycle of a match
    s_next.match_prev = (cur_class == CLASS_COMPARE) ? match : 1'b0;
    if ((cur_class == CLASS_COMPARE) && match_edge)
    begin
      unique case (cur_mode)
        `MODE_CMP_SET: s_next.compare_latch = 1'b1;
        `MODE_CMP_CLEAR: s_next.compare_latch = 1'b0;
        `MODE_CMP_SOFT: s_next.compare_latch = s_reg.compare_latch;
        `MODE_CMP_TRIG: s_next.trigger = 1'b1;
        default: s_next.compare_latch = s_reg.compare_latch;
      endcase
    end

    // PWM: period end reloads the duty and sets the pin unless the duty is zero; duty match clears it.
    // A duty beyond the period never matches, so the pin stays high.
    if (cur_class == CLASS_PWM)
    begin
      if (period_end)
      begin
        s_next.value_high = s_reg.value_low;
        s_next.duty_latch = s_reg.control[`CTL_DUTY_MSB:`CTL_DUTY_LSB];
        s_next.pwm_latch = (duty_new != '0);
      end
      else if (duty_live == t2_ext)
      begin
        s_next.pwm_latch = 1'b0;
      end
    end

    // Mode effects of the value now being written
    new_class = mode_class(s_next.control[`CTL_MODE_MSB:`CTL_MODE_LSB]);
    if (new_class != CLASS_CAPTURE)
    begin
      s_next.prescale_count = `PRESC_ZERO;
    end
    if (s_next.control[`CTL_MODE_MSB:`CTL_MODE_LSB] == `MODE_OFF)
    begin
      s_next.compare_latch = 1'b0;
      s_next.pwm_latch = 1'b0;
      s_next.duty_latch = `DUTY_ZERO;
      s_next.match_prev = 1'b0;
      s_next.trigger = 1'b0;
    end

    // Event flag: a set in the cycle of a clear wins; only the clear
    // input lowers the flag
    s_next.event_flag = (s_reg.event_flag & ~event_flag_clear) | capture_hit
      | ((cur_class == CLASS_COMPARE) && match_edge);
    s_next.event_irq = s_next.event_flag & event_enable;

    // Pin ownership and output level follow the class being entered
    unique case (new_class)
      CLASS_COMPARE: s_next.pin_out = s_next.compare_latch;
      CLASS_PWM: s_next.pin_out = s_next.pwm_latch;
      CLASS_CAPTURE: s_next.pin_out = 1'b0;
      CLASS_OFF: s_next.pin_out = 1'b0;
    endcase
    s_next.pin_owned = (new_class == CLASS_COMPARE) || (new_class == CLASS_PWM);

    // Read data stand only in the cycle after the strobe
    s_next.rdata = `BYTE_ZERO;
    if (reg_rd)
    begin
      if (reg_addr == CTL_ADDR)
      begin
        s_next.rdata = {`CTL_PAD, s_reg.control};
      end
      else if (reg_addr == LOW_ADDR)
      begin
        s_next.rdata = s_reg.value_low;
      end
      else if (reg_addr == HIGH_ADDR)
      begin
        s_next.rdata = s_reg.value_high;
      end
    end
  end

  // =====================================================================
  // State register
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // =====================================================================
  // Outputs, each straight from the state register.
  // The trigger is a separate clear request to timer1; timer1 must treat
  // it apart from its overflow path so no overflow flag is raised.
  assign special_event_trigger = s_reg.trigger;
  assign reg_rdata = s_reg.rdata;
  assign event_flag = s_reg.event_flag;
  assign event_irq = s_reg.event_irq;
  assign pin_out = s_reg.pin_out;
  assign pin_owned = s_reg.pin_owned;

endmodule : capcmp_unit

// File: bench/capcmp_unit_assertions.sv
`timescale 1ns/1ps

module capcmp_checker
  import capcmp_pkg::*;
#(
  parameter logic [7:0] CTL_ADDR = 8'h17
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Events and pin
  input wire logic special_event_trigger,
  input wire logic event_flag_clear,
  input wire logic event_enable,
  input wire logic event_flag,
  input wire logic event_irq,
  input wire logic pin_in,
  input wire logic pin_out,
  input wire logic pin_owned
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  // ======================================================
  // Shadow of the mode field, tracked from bus writes
  logic [3:0] mode_q;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      mode_q <= 4'h0;
    else if (reg_wr && reg_addr == CTL_ADDR)
      mode_q <= reg_wdata[3:0];
  end

  // ======================================================
  // Properties
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
  a_ctl_top_zero: assert property ($past(reg_rd) && $past(reg_addr) == CTL_ADDR |-> reg_rdata[7:6] == 2'h0)
    else $error("control top bits not zero");
  a_trig_pulse: assert property (special_event_trigger |=> !special_event_trigger) else $error("trigger too long");
  a_trig_mode: assert property (special_event_trigger |-> event_flag && $past(mode_q) == 4'hB)
    else $error("trigger outside its mode");
  a_flag_sticky: assert property ($past(event_flag) && !$past(event_flag_clear) |-> event_flag)
    else $error("flag dropped by hardware");
  a_irq_follow: assert property (event_irq == (event_flag && $past(event_enable))) else $error("irq mismatch");
  a_off_latch_low: assert property ($past(reg_wr) && $past(reg_addr) == CTL_ADDR && $past(reg_wdata) == 8'h00
    |=> !pin_out) else $error("latch not low after off");
  a_capt_rise: assert property (mode_q == 4'h5 && $rose(pin_in) |-> ##[1:4] event_flag)
    else $error("rise not captured");
  a_off_quiet: assert property ($past(mode_q) == 4'h0 && mode_q == 4'h0 |-> !pin_out && !pin_owned)
    else $error("pin active while off");
endmodule : capcmp_checker

bind capcmp_unit capcmp_checker #(.CTL_ADDR(CTL_ADDR)) capcmp_checker_i (.clk(clk), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .special_event_trigger(special_event_trigger), .event_flag_clear(event_flag_clear),
  .event_enable(event_enable), .event_flag(event_flag), .event_irq(event_irq), .pin_in(pin_in),
  .pin_out(pin_out), .pin_owned(pin_owned));

// File: bench/pin_partner.sv
`timescale 1ns/1ps

module pin_partner
(
  // Levels offered by the outside source and the port latch
  input wire logic ext_level,
  input wire logic port_drive,
  input wire logic port_level,
  // Unit output side
  input wire logic pin_out,
  input wire logic pin_owned,
  // Pad level seen by the unit
  output logic pin_in
);
  // Port latch wins when driving, so a port write can make a capture edge
  assign pin_in = port_drive ? port_level : (pin_owned ? pin_out : ext_level);
endmodule : pin_partner

// File: bench/tb_top.sv
`timescale 1ns/1ps
`include "capcmp_params.svh"

module tb_top;
  import capcmp_pkg::*;
  // ======================================================
  // Signals
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, t2 = 8'h00;
  logic reg_wr = 1'h0, reg_rd = 1'h0, t2_on = 1'h0, fclr = 1'h0, ev_en = 1'h1, t1_run = 1'h0;
  logic ext = 1'h0, pdrv = 1'h0, pin_in, pin_out, pin_owned, trig, flag, irq;
  logic [15:0] t1 = 16'h0000, t1_set = 16'h0000;
  logic t1_ld = 1'h0;
  logic [1:0] ph = 2'h0;
  int n_fail = 0, samples_checked = 0, n_trig = 0, n_high;

  capcmp_unit capcmp_unit_i (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer1_count(t1),
    .special_event_trigger(trig), .timer2_count(t2), .timer2_period(8'h07), .timer2_tick(t2_on && ph == 2'h3),
    .timer2_phase(ph), .event_flag_clear(fclr), .event_enable(ev_en), .event_flag(flag),
    .event_irq(irq), .pin_in(pin_in), .pin_out(pin_out), .pin_owned(pin_owned));
  pin_partner pin_partner_i (.ext_level(ext), .port_drive(pdrv), .port_level(ext), .pin_out(pin_out),
    .pin_owned(pin_owned), .pin_in(pin_in));

  // ======================================================
  // Clock, timer models and watchdog
  initial forever #5 clk = ~clk;
  // Timer1 is cleared by the trigger, never by an overflow path
  always @(posedge clk)
  begin
    if (trig)
      t1 <= 16'h0000;
    else if (t1_ld)
      t1 <= t1_set;
    else if (t1_run)
      t1 <= t1 + 16'h0001;
    if (trig)
      n_trig++;
    // Timer2 steps once every four phases; the phase is its low extension
    if (t2_on)
    begin
      ph <= ph + 2'h1;
      if (ph == 2'h3)
        t2 <= (t2 == 8'h07) ? 8'h00 : t2 + 8'h01;
    end
  end
  initial
  begin
    #100000;
    n_fail++;
    give_verdict();
  end

  // ======================================================
  // Tasks
  task automatic give_verdict();
    if (n_fail == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask : wr
  // Read data lives only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
  endtask : rd
  task automatic pulse();
    @(posedge clk);
    ext <= 1'h1;
    repeat (6) @(posedge clk);
    ext <= 1'h0;
    repeat (6) @(posedge clk);
  endtask : pulse
  task automatic clr_flag();
    @(posedge clk);
    fclr <= 1'h1;
    @(posedge clk);
    fclr <= 1'h0;
  endtask : clr_flag
  // Timer1 is loaded through its model so it keeps a single driver
  task automatic load_t1(input logic [15:0] v);
    @(posedge clk);
    t1_set <= v;
    t1_ld <= 1'h1;
    @(posedge clk);
    t1_ld <= 1'h0;
  endtask : load_t1
  // Off first, so the prescaler starts from zero
  task automatic capt(input logic [3:0] m, input int d, input int k);
    wr(`UNIT1_CTL_ADDR, 8'h00);
    wr(`UNIT1_CTL_ADDR, {4'h0, m});
    clr_flag();
    for (int i = 0; i < k; i++)
    begin
      load_t1(16'h4A00 + 16'(i));
      pulse();
      chk("event_flag", 16'((i + 1) >= d), {15'h0, flag});
    end
    rd(`UNIT1_LOW_ADDR, 8'(k - 1));
    rd(`UNIT1_HIGH_ADDR, 8'h4A);
  endtask : capt
  task automatic cmpm(input logic [3:0] m, input logic e_pin);
    wr(`UNIT1_CTL_ADDR, {4'h0, m});
    clr_flag();
    load_t1(16'h1230);
    t1_run <= 1'h1;
    repeat (12) @(posedge clk);
    t1_run <= 1'h0;
    #1;
    chk("event_flag", 16'h0001, {15'h0, flag});
    chk("pin_out", {15'h0, e_pin}, {15'h0, pin_out});
    chk("event_irq", {15'h0, ev_en}, {15'h0, irq});
    chk("pin_owned", 16'h0001, {15'h0, pin_owned});
  endtask : cmpm
  // One timer2 period is 32 clocks; settle past a period end, then count one period
  task automatic duty(input int e);
    repeat (40) @(posedge clk);
    n_high = 0;
    repeat (32)
    begin
      @(posedge clk);
      #1;
      n_high += int'(pin_out);
    end
    chk("pwm_high", 16'(e), 16'(n_high));
  endtask : duty

  // ======================================================
  // Test sequence
  initial
  begin
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    rd(`UNIT1_CTL_ADDR, 8'h00);
    rd(`UNIT1_LOW_ADDR, 8'h00);
    rd(8'h20, 8'h00);
    wr(`UNIT1_LOW_ADDR, 8'hA5);
    wr(`UNIT1_HIGH_ADDR, 8'h5A);
    wr(`UNIT1_CTL_ADDR, 8'hF4);
    rd(`UNIT1_LOW_ADDR, 8'hA5);
    rd(`UNIT1_HIGH_ADDR, 8'h5A);
    rd(`UNIT1_CTL_ADDR, 8'h34);
    capt(4'h4, 1, 2);
    capt(4'h5, 1, 2);
    capt(4'h6, 4, 4);
    capt(4'h7, 16, 16);
    pdrv <= 1'h1;
    capt(4'h5, 1, 2);
    pdrv <= 1'h0;
    wr(`UNIT1_CTL_ADDR, 8'h00);
    wr(`UNIT1_LOW_ADDR, 8'h34);
    wr(`UNIT1_HIGH_ADDR, 8'h12);
    cmpm(4'h8, 1'h1);
    @(posedge clk);
    ev_en <= 1'h0;
    cmpm(4'hA, 1'h1);
    @(posedge clk);
    ev_en <= 1'h1;
    cmpm(4'h9, 1'h0);
    cmpm(4'hB, 1'h0);
    chk("trigger_count", 16'h0001, 16'(n_trig));
    chk("timer1_cleared", 16'h0001, {15'h0, t1 < 16'h0020});
    cmpm(4'h8, 1'h1);
    wr(`UNIT1_CTL_ADDR, 8'h00);
    repeat (3) @(posedge clk);
    chk("pin_out", 16'h0000, {15'h0, pin_out});
    wr(`UNIT1_LOW_ADDR, 8'h03);
    wr(`UNIT1_CTL_ADDR, 8'h0C);
    t2_on <= 1'h1;
    // Pin is high from the period end through the cycle in which the duty match is seen
    duty(13);
    wr(`UNIT1_HIGH_ADDR, 8'h77);
    rd(`UNIT1_HIGH_ADDR, 8'h03);
    wr(`UNIT1_CTL_ADDR, 8'h1C);
    duty(14);
    wr(`UNIT1_LOW_ADDR, 8'h00);
    wr(`UNIT1_CTL_ADDR, 8'h0C);
    duty(0);
    wr(`UNIT1_LOW_ADDR, 8'h02);
    duty(9);
    wr(`UNIT1_CTL_ADDR, 8'h00);
    repeat (4) @(posedge clk);
    chk("pin_out", 16'h0000, {15'h0, pin_out});
    give_verdict();
  end
endmodule : tb_top
